//--- efl_pkg.sv
/*
 * shared constants and types for the ethernet frame fifo, loopback and
 * pattern generator block.
 * assumes a single 40 mhz clock and byte-wide frame streams.
 */
`default_nettype none
package efl_pkg;
	localparam int DEPTH = 4096;
	typedef logic [11:0] efl_ptr_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
		logic       user;
	} efl_axis_s;

	typedef enum logic [1:0] {
		SW_FILL = 2'b00,
		SW_HDR  = 2'b01,
		SW_BODY = 2'b10
	} efl_swap_e;

	typedef enum logic [1:0] {
		CK_SYNC = 2'b00,
		CK_RUN  = 2'b01,
		CK_SKIP = 2'b10
	} efl_chk_e;

	// register map, byte offsets on the plain register port
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CLEAR  = 4'h8;
	localparam int CTRL_SWAP = 0;
	localparam int CTRL_GEN  = 1;
	localparam int CTRL_CHK  = 2;
	localparam logic [2:0] CTRL_RST = 3'h1;
	localparam int ST_ERR = 0;
	localparam int ST_ACT = 1;
	localparam int CLR_ERR = 0;

	// generated frame layout; address values are arbitrary
	localparam logic [47:0] GEN_DA = 48'h0a0b0c0d0e0f;
	localparam logic [47:0] GEN_SA = 48'h1a1b1c1d1e1f;
	localparam logic [15:0] GEN_MIN_LEN = 16'h002e;
	localparam logic [15:0] GEN_MAX_LEN = 16'h05dc;
	localparam logic [3:0]  HDR_LEN  = 4'hc;
	localparam logic [3:0]  ADDR_LEN = 4'h6;
	localparam logic [15:0] TL_HI_IDX = 16'h000c;
	localparam logic [15:0] TL_LO_IDX = 16'h000d;
	localparam logic [15:0] PAY_IDX   = 16'h000e;
	localparam logic [7:0]  LAST_BYTE = 8'h01;
	// one stalled cycle in every THR_DIV keeps the generator under line rate
	localparam logic [5:0]  THR_DIV = 6'h32;
endpackage
`default_nettype wire

//--- efl_eth_fifo.sv
/*
 * receive and transmit frame fifos with the loopback / pattern generator
 * path between them, plus the pattern checker and a small register port.
 * assumes the mac streams and the register port are synchronous to clk.
 */
// Summary of operation
// - receive fifo holds 4,095 bytes and takes bytes from the mac
// - only good frames leave the receive fifo; errored ones vanish
// - on receive overflow the current frame is dropped and flagged
// - transmit fifo holds 4095 bytes, filled from the user side
// - a frame goes to the mac only once fully stored
// - transmit fifo drops write ready when full, raises it when free
// - full with no whole frame: flag overflow, swallow and drop it
// - loopback via address swap, or generator with optional checker
// - swap stage waits for both address fields, or the frame end, before forwarding
// - swap exchanges destination and source when enabled
// - control markers see the same latency as data
// - generator mode flushes receive output; generator feeds swap
// - generator sizes climb from minimum to maximum then wrap
// - fixed addresses, length field, payload counts down to 0x1
// - generator runs slightly below line rate
// - checker uses generator settings, either address either place
// - checker syncs on length then expects one step larger each
// - mismatch flags error, latches it, and resynchronises
// - clear input drops the latched error
// - activity output toggles for each correctly received frame
`timescale 1ns/1ps
`default_nettype none
module efl_eth_fifo
	import efl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire efl_axis_s   mac_rx,
	output efl_axis_s        mac_tx,
	input  wire logic        mac_tx_ready,
	output logic             rx_overflow,
	output logic             tx_overflow,
	output logic             chk_error,
	output logic             chk_activity
);
	function automatic efl_ptr_t ptr_inc(input efl_ptr_t p);
		return p + 12'h001;
	endfunction

	function automatic logic [7:0] gen_byte(input logic [15:0] bi,
		input logic [15:0] tl);
		logic [95:0] hw;
		logic [15:0] v;
		hw = {GEN_DA, GEN_SA} << {bi[3:0], 3'b000};
		v = tl - (bi - PAY_IDX);
		if (bi < {12'h000, HDR_LEN})
			return hw[95:88];
		else if (bi == TL_HI_IDX)
			return tl[15:8];
		else if (bi == TL_LO_IDX)
			return tl[7:0];
		else
			return v[7:0];
	endfunction

	function automatic logic [3:0] swap_idx(input logic [3:0] i);
		return (i < ADDR_LEN) ? i + ADDR_LEN : i - ADDR_LEN;
	endfunction

	function automatic logic [15:0] len_next(input logic [15:0] tl);
		return (tl >= GEN_MAX_LEN) ? GEN_MIN_LEN : tl + 16'h0001;
	endfunction

	logic [2:0]  ctrl_reg;
	logic        err_clear;
	logic [8:0]  rx_mem [DEPTH];
	logic [8:0]  tx_mem [DEPTH];
	efl_ptr_t    rx_wr_reg, rx_sof_reg, rx_cmt_reg, rx_rd_reg;
	efl_ptr_t    tx_wr_reg, tx_sof_reg, tx_cmt_reg, tx_rd_reg;
	logic        rx_drop_reg, tx_drop_reg;
	logic        rx_full, rx_we, rx_valid, rx_ready, rx_pop;
	logic [8:0]  rx_word;
	logic        tx_full, tx_nofrm, tx_in_ready, tx_hs, tx_we, tx_load;
	efl_axis_s   sw_in, sw_out, gen_out;
	logic        sw_in_ready, sw_in_hs, sw_out_hs;
	efl_swap_e   sw_state;
	logic [3:0]  sw_cnt, sw_idx, sw_n, sw_map;
	logic        sw_do, sw_short;
	logic [8:0]  sw_hdr [12];
	logic        sel_gen_reg, lb_mid_reg, gen_ready, gen_hs;
	logic [15:0] gen_bi, gen_tl;
	logic [5:0]  thr_cnt;
	efl_chk_e    chk_state;
	logic [15:0] chk_ci, chk_exp;
	logic [7:0]  chk_hi;
	logic        chk_hs, chk_bad;

	// register port: control steers the datapath, status shows checker state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			ctrl_reg <= CTRL_RST;
		else if (reg_wr && reg_addr == REG_CTRL)
			ctrl_reg <= reg_wdata[2:0];
	end

	assign err_clear = reg_wr && reg_addr == REG_CLEAR && reg_wdata[CLR_ERR];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd) begin
			if (reg_addr == REG_CTRL)
				reg_rdata <= {29'h00000000, ctrl_reg};
			else if (reg_addr == REG_STATUS)
				reg_rdata <= {30'h00000000, chk_activity, chk_error};
			else
				reg_rdata <= 32'h00000000;
		end
	end

	// receive fifo; commit pointer only moves past good, complete frames
	assign rx_full = ptr_inc(rx_wr_reg) == rx_rd_reg;
	assign rx_we = mac_rx.valid && !rx_drop_reg && !rx_full;

	always_ff @(posedge clk) begin
		if (rx_we)
			rx_mem[rx_wr_reg] <= {mac_rx.data, mac_rx.last};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_wr_reg   <= 12'h000;
			rx_sof_reg  <= 12'h000;
			rx_cmt_reg  <= 12'h000;
			rx_drop_reg <= 1'b0;
			rx_overflow <= 1'b0;
		end else begin
			rx_overflow <= 1'b0;
			if (mac_rx.valid) begin
				if (rx_drop_reg) begin
					if (mac_rx.last)
						rx_drop_reg <= 1'b0;
				end else if (rx_full) begin
					rx_wr_reg   <= rx_sof_reg;
					rx_drop_reg <= !mac_rx.last;
					rx_overflow <= 1'b1;
				end else if (mac_rx.last && mac_rx.user) begin
					rx_wr_reg <= rx_sof_reg;
				end else if (mac_rx.last) begin
					rx_wr_reg  <= ptr_inc(rx_wr_reg);
					rx_sof_reg <= ptr_inc(rx_wr_reg);
					rx_cmt_reg <= ptr_inc(rx_wr_reg);
				end else
					rx_wr_reg <= ptr_inc(rx_wr_reg);
			end
		end
	end

	assign rx_valid = rx_rd_reg != rx_cmt_reg;
	assign rx_word = rx_mem[rx_rd_reg];
	assign rx_pop = rx_valid && rx_ready;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rx_rd_reg <= 12'h000;
		else if (rx_pop)
			rx_rd_reg <= ptr_inc(rx_rd_reg);
	end

	// source select changes only with lb_mid_reg clear and gen_bi at 0; a receive frame whose first byte pops that cycle is cut
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_gen_reg <= 1'b0;
			lb_mid_reg  <= 1'b0;
		end else begin
			if (rx_pop && !sel_gen_reg)
				lb_mid_reg <= !rx_word[0];
			if (!lb_mid_reg && gen_bi == 16'h0000)
				sel_gen_reg <= ctrl_reg[CTRL_GEN];
		end
	end

	assign rx_ready = sel_gen_reg ? 1'b1 : sw_in_ready;
	assign gen_ready = sel_gen_reg && sw_in_ready;
	always_comb begin
		if (sel_gen_reg)
			sw_in = gen_out;
		else
			sw_in = '{valid: rx_valid, data: rx_word[8:1],
				last: rx_word[0], user: 1'b0};
	end

	// pattern generator
	assign gen_out.valid = sel_gen_reg && thr_cnt != 6'h00 &&
		(ctrl_reg[CTRL_GEN] || gen_bi != 16'h0000);
	assign gen_out.data = gen_byte(gen_bi, gen_tl);
	assign gen_out.last = gen_bi == gen_tl + TL_LO_IDX;
	assign gen_out.user = 1'b0;
	assign gen_hs = gen_out.valid && gen_ready;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			thr_cnt <= 6'h01;
		else if (thr_cnt == THR_DIV - 6'h01)
			thr_cnt <= 6'h00;
		else
			thr_cnt <= thr_cnt + 6'h01;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gen_bi <= 16'h0000;
			gen_tl <= GEN_MIN_LEN;
		end else if (gen_hs) begin
			if (gen_out.last) begin
				gen_bi <= 16'h0000;
				gen_tl <= len_next(gen_tl);
			end else
				gen_bi <= gen_bi + 16'h0001;
		end
	end

	// address swap: holds the twelve address bytes with their last marks
	assign sw_in_hs = sw_in.valid && sw_in_ready;
	assign sw_out_hs = sw_out.valid && tx_in_ready;
	assign sw_map = sw_do ? swap_idx(sw_idx) : sw_idx;

	always_comb begin
		sw_in_ready = 1'b0;
		sw_out = '{valid: 1'b0, data: 8'h00, last: 1'b0, user: 1'b0};
		case (sw_state)
			SW_FILL: sw_in_ready = 1'b1;
			SW_HDR: begin
				sw_out.valid = 1'b1;
				sw_out.data = sw_hdr[sw_map][8:1];
				// the end mark keeps its place; only address bytes move
				sw_out.last = sw_hdr[sw_idx][0];
			end
			SW_BODY: begin
				sw_in_ready = tx_in_ready;
				sw_out = sw_in;
			end
			default: sw_in_ready = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sw_state == SW_FILL && sw_in_hs)
			sw_hdr[sw_cnt] <= {sw_in.data, sw_in.last};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sw_state <= SW_FILL;
			sw_cnt   <= 4'h0;
			sw_idx   <= 4'h0;
			sw_n     <= 4'h0;
			sw_do    <= 1'b0;
			sw_short <= 1'b0;
		end else begin
			case (sw_state)
				SW_FILL: if (sw_in_hs) begin
					if (sw_in.last || sw_cnt == HDR_LEN - 4'h1) begin
						sw_state <= SW_HDR;
						sw_n     <= sw_cnt + 4'h1;
						sw_short <= sw_in.last;
						sw_do    <= ctrl_reg[CTRL_SWAP] &&
							sw_cnt == HDR_LEN - 4'h1;
						sw_idx   <= 4'h0;
					end else
						sw_cnt <= sw_cnt + 4'h1;
				end
				SW_HDR: if (sw_out_hs) begin
					if (sw_idx == sw_n - 4'h1) begin
						sw_state <= sw_short ? SW_FILL : SW_BODY;
						sw_cnt   <= 4'h0;
					end else
						sw_idx <= sw_idx + 4'h1;
				end
				SW_BODY: if (sw_in_hs && sw_in.last)
					sw_state <= SW_FILL;
				default: sw_state <= SW_FILL;
			endcase
		end
	end

	// transmit fifo
	assign tx_full = ptr_inc(tx_wr_reg) == tx_rd_reg;
	assign tx_nofrm = tx_cmt_reg == tx_rd_reg;
	// a full fifo with no whole frame must keep taking bytes or it deadlocks
	assign tx_in_ready = tx_drop_reg || !tx_full || tx_nofrm;
	assign tx_hs = sw_out.valid && tx_in_ready;
	assign tx_we = tx_hs && !tx_drop_reg && !tx_full;

	always_ff @(posedge clk) begin
		if (tx_we)
			tx_mem[tx_wr_reg] <= {sw_out.data, sw_out.last};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_wr_reg   <= 12'h000;
			tx_sof_reg  <= 12'h000;
			tx_cmt_reg  <= 12'h000;
			tx_drop_reg <= 1'b0;
			tx_overflow <= 1'b0;
		end else begin
			tx_overflow <= 1'b0;
			if (tx_hs) begin
				if (tx_drop_reg) begin
					if (sw_out.last)
						tx_drop_reg <= 1'b0;
				end else if (tx_full) begin
					tx_wr_reg   <= tx_sof_reg;
					tx_drop_reg <= !sw_out.last;
					tx_overflow <= 1'b1;
				end else if (sw_out.last) begin
					tx_wr_reg  <= ptr_inc(tx_wr_reg);
					tx_sof_reg <= ptr_inc(tx_wr_reg);
					tx_cmt_reg <= ptr_inc(tx_wr_reg);
				end else
					tx_wr_reg <= ptr_inc(tx_wr_reg);
			end
		end
	end

	// output stage waits on the mac's ready while it gains the medium
	assign tx_load = !mac_tx.valid || mac_tx_ready;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mac_tx    <= '{valid: 1'b0, data: 8'h00, last: 1'b0, user: 1'b0};
			tx_rd_reg <= 12'h000;
		end else if (tx_load) begin
			if (!tx_nofrm) begin
				mac_tx.valid <= 1'b1;
				mac_tx.data  <= tx_mem[tx_rd_reg][8:1];
				mac_tx.last  <= tx_mem[tx_rd_reg][0];
				tx_rd_reg    <= ptr_inc(tx_rd_reg);
			end else
				mac_tx.valid <= 1'b0;
		end
	end

	// pattern checker on the receive fifo output
	assign chk_hs = rx_pop && ctrl_reg[CTRL_CHK];

	always_comb begin
		chk_bad = 1'b0;
		if (chk_state != CK_SKIP) begin
			if (chk_ci < {12'h000, HDR_LEN})
				chk_bad = rx_word[8:1] != gen_byte(chk_ci, chk_exp) &&
					rx_word[8:1] != gen_byte({12'h000,
					swap_idx(chk_ci[3:0])}, chk_exp);
			else if (chk_state == CK_RUN) begin
				chk_bad = rx_word[8:1] != gen_byte(chk_ci, chk_exp) ||
					rx_word[0] != (chk_ci == chk_exp + TL_LO_IDX);
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			chk_ci <= 16'h0000;
		else if (rx_pop)
			chk_ci <= rx_word[0] ? 16'h0000 : chk_ci + 16'h0001;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chk_state    <= CK_SYNC;
			chk_exp      <= GEN_MIN_LEN;
			chk_hi       <= 8'h00;
			chk_activity <= 1'b0;
		end else if (!ctrl_reg[CTRL_CHK])
			chk_state <= CK_SYNC;
		else if (chk_hs) begin
			case (chk_state)
				CK_SYNC: begin
					if (chk_bad)
						chk_state <= rx_word[0] ? CK_SYNC : CK_SKIP;
					else if (chk_ci == TL_HI_IDX)
						chk_hi <= rx_word[8:1];
					else if (chk_ci == TL_LO_IDX && !rx_word[0]) begin
						chk_exp   <= {chk_hi, rx_word[8:1]};
						chk_state <= CK_RUN;
					end
				end
				CK_RUN: begin
					if (chk_bad)
						chk_state <= rx_word[0] ? CK_SYNC : CK_SKIP;
					else if (rx_word[0]) begin
						chk_exp      <= len_next(chk_exp);
						chk_activity <= !chk_activity;
					end
				end
				CK_SKIP: if (rx_word[0])
					chk_state <= CK_SYNC;
				default: chk_state <= CK_SYNC;
			endcase
		end
	end

	// a fresh error wins over a clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			chk_error <= 1'b0;
		else if (chk_hs && chk_bad)
			chk_error <= 1'b1;
		else if (err_clear)
			chk_error <= 1'b0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	rx_bad_drop_a: assert property (rx_we && mac_rx.last && mac_rx.user
		|=> rx_cmt_reg == $past(rx_cmt_reg) && rx_wr_reg == $past(rx_sof_reg))
		else $error("errored frame was committed");
	rx_ovf_drop_a: assert property (mac_rx.valid && !rx_drop_reg && rx_full
		|=> rx_overflow && rx_wr_reg == $past(rx_sof_reg) ##1 !rx_overflow)
		else $error("receive overflow not handled");
	tx_whole_frame_a: assert property (tx_load && tx_nofrm
		|=> !mac_tx.valid)
		else $error("transmit started before frame complete");
	tx_full_stall_a: assert property (tx_full && !tx_nofrm && !tx_drop_reg
		|-> !tx_in_ready)
		else $error("transmit ready high while full");
	tx_ovf_take_a: assert property (sw_out.valid && tx_full && tx_nofrm
		&& !tx_drop_reg |-> tx_in_ready ##1 tx_overflow)
		else $error("transmit overflow not handled");
	swap_wait_a: assert property (sw_state == SW_FILL |-> !sw_out.valid)
		else $error("swap stage forwarded before addresses");
	swap_map_a: assert property (sw_state == SW_HDR && sw_do
		|-> sw_out.data == sw_hdr[swap_idx(sw_idx)][8:1])
		else $error("address swap wrong");
	swap_end_a: assert property (sw_state == SW_HDR && sw_out.last
		|-> sw_short && sw_idx == sw_n - 4'h1)
		else $error("swap stage end mark misplaced");
	gen_flush_a: assert property (sel_gen_reg && rx_valid |-> rx_pop)
		else $error("receive output not flushed");
	gen_wrap_a: assert property (gen_hs && gen_out.last
		&& gen_tl == GEN_MAX_LEN |=> gen_tl == GEN_MIN_LEN)
		else $error("generator did not wrap");
	gen_tail_a: assert property (gen_hs && gen_out.last
		|-> gen_out.data == LAST_BYTE)
		else $error("last generated byte wrong");
	gen_rate_a: assert property (thr_cnt == 6'h00 |-> !gen_out.valid)
		else $error("generator not throttled");
	chk_latch_a: assert property (chk_hs && chk_bad
		|=> chk_error && chk_state != CK_RUN)
		else $error("checker error not latched");
	err_clear_a: assert property (err_clear && !(chk_hs && chk_bad)
		|=> !chk_error)
		else $error("error not cleared");

	rx_ovf_c: cover property (rx_overflow);
	tx_ovf_c: cover property (tx_overflow);
	gen_wrap_c: cover property (gen_hs && gen_out.last && gen_tl == GEN_MAX_LEN);
	chk_good_c: cover property (chk_state == CK_RUN ##1 $changed(chk_activity));
endmodule
`default_nettype wire

//--- efl_mac_model.sv
/*
 * mac side of the frame fifo block: receive byte source and transmit sink.
 * assumes one clock shared with the block and bench-supplied coin flips.
 */
`timescale 1ns/1ps
`default_nettype none
module efl_mac_model
	import efl_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      nrst,
	input  wire efl_axis_s mac_tx,
	input  wire logic      hold,
	input  wire logic      slow,
	input  wire logic      coin,
	input  wire logic      loop,
	input  wire logic      corrupt,
	output efl_axis_s      mac_rx,
	output logic           mac_tx_ready
);
	efl_axis_s q[$];
	logic      spoil_reg;
	logic      take;

	assign take = mac_tx.valid && mac_tx_ready;

	// frames queue up and leave one byte a cycle; callers queue up to 4164 bytes
	task automatic send(input logic [7:0] b[$], input logic bad);
		foreach (b[i]) begin
			q.push_back('{1'b1, b[i], i == b.size() - 1,
				bad && i == b.size() - 1});
		end
	endtask

	// ready stays low while the medium is not ours
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			mac_tx_ready <= 1'b0;
		else
			mac_tx_ready <= !hold && (!slow || coin);
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			mac_rx <= '0;
		else if (q.size() != 0)
			mac_rx <= q.pop_front();
		else if (loop && take)
			mac_rx <= '{1'b1, mac_tx.data ^ {8{spoil_reg}}, mac_tx.last, 1'b0};
		else
			// idle lines wander so a stale byte never looks current
			mac_rx <= '{1'b0, ~mac_rx.data, 1'b0, 1'b0};
	end

	// one echoed byte is spoiled after each corrupt request
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			spoil_reg <= 1'b0;
		else if (corrupt)
			spoil_reg <= 1'b1;
		else if (loop && take && q.size() == 0)
			spoil_reg <= 1'b0;
	end
endmodule
`default_nettype wire

//--- eth_frame_fifo_loopback_patgen_bench.sv
/*
 * self-checking bench for the frame fifo, loopback and pattern block.
 * assumes the mac model file is compiled first and one 40 mhz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	failures++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); \
	end end
module eth_frame_fifo_loopback_patgen_bench
	import efl_pkg::*;
;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	efl_axis_s   mac_rx;
	efl_axis_s   mac_tx;
	logic        mac_tx_ready;
	logic        rx_overflow;
	logic        tx_overflow;
	logic        chk_error;
	logic        chk_activity;
	logic        hold = 1'b0;
	logic        slow = 1'b0;
	logic        coin = 1'b0;
	logic        loop = 1'b0;
	logic        corrupt = 1'b0;
	logic        strict = 1'b1;
	logic        whole_chk = 1'b0;
	logic        rd_pend = 1'b0;
	logic        act_prev = 1'b0;
	logic [31:0] seed = 32'h8d7c;
	logic [8:0]  tx_q[$];
	logic [63:0] rd_q[$];
	logic [7:0]  fr[$];
	int          failures = 0;
	int          comparisons = 0;
	int          rx_ovf_n = 0;
	int          tx_ovf_n = 0;
	int          act_n = 0;
	int          lens[5] = '{60, 40, 12, 8, 97};

	always #12.5 clk = ~clk;

	efl_eth_fifo u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mac_rx(mac_rx), .mac_tx(mac_tx),
		.mac_tx_ready(mac_tx_ready), .rx_overflow(rx_overflow),
		.tx_overflow(tx_overflow), .chk_error(chk_error),
		.chk_activity(chk_activity));

	efl_mac_model u_mac (.clk(clk), .nrst(nrst), .mac_tx(mac_tx),
		.hold(hold), .slow(slow), .coin(coin), .loop(loop),
		.corrupt(corrupt), .mac_rx(mac_rx), .mac_tx_ready(mac_tx_ready));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic wrap_up();
		if (failures == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic mk_frame(input int len);
		logic [31:0] r;
		fr.delete();
		for (int i = 0; i < len; i++) begin
			r = xs();
			fr.push_back(r[7:0]);
		end
	endtask

	// short frames lack both address fields and pass as they are
	task automatic expect_frame(input logic sw);
		int k;
		foreach (fr[i]) begin
			k = (sw && fr.size() >= 12 && i < 12) ? (i < 6 ? i + 6 : i - 6) : i;
			tx_q.push_back({i == fr.size() - 1, fr[k]});
		end
	endtask

	task automatic gen_expect(input logic [15:0] len);
		fr.delete();
		for (int k = 0; k < 6; k++)
			fr.push_back(GEN_DA[47 - 8 * k -: 8]);
		for (int k = 0; k < 6; k++)
			fr.push_back(GEN_SA[47 - 8 * k -: 8]);
		fr.push_back(len[15:8]);
		fr.push_back(len[7:0]);
		for (logic [15:0] v = len; v != 0; v--)
			fr.push_back(v[7:0]);
		expect_frame(1'b0);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e,
			input logic [31:0] m = 32'hffffffff);
		rd_q.push_back({m, e});
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic drain(input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			if (tx_q.size() == 0 && u_mac.q.size() == 0)
				break;
			@(posedge clk);
		end
		if (i == lim) begin
			failures++;
			wrap_up();
		end
	endtask

	always @(posedge clk) begin
		logic [31:0] r;
		r = xs();
		coin <= r[4];
	end

	always @(posedge clk) begin
		logic [63:0] ent;
		logic [8:0]  e9;
		rd_pend <= reg_rd;
		if (rd_pend) begin
			ent = rd_q.pop_front();
			`CHK(reg_rdata & ent[63:32], ent[31:0])
		end
		if (mac_tx.valid && mac_tx_ready) begin
			if (tx_q.size() != 0) begin
				e9 = tx_q.pop_front();
				`CHK({mac_tx.user, mac_tx.last, mac_tx.data}, {1'b0, e9})
			end else if (strict)
				`CHK(mac_tx.valid, 1'b0)
		end
		if (whole_chk && mac_tx.valid)
			`CHK(u_mac.q.size(), 0)
		if (rx_overflow === 1'b1)
			rx_ovf_n++;
		if (tx_overflow === 1'b1)
			tx_ovf_n++;
		if (chk_activity !== act_prev)
			act_n++;
		act_prev <= chk_activity;
	end

	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		`CHK({mac_tx.valid, rx_overflow, tx_overflow, chk_error}, 4'h0)
		rd(REG_CTRL, 32'h1);
		rd(REG_STATUS, 32'h0);
		wr(REG_STATUS, 32'hffffffff);
		rd(REG_STATUS, 32'h0);
		rd(4'hc, 32'h0);
		// back to back frames, the second errored, then ones of 12, 8 and 97 bytes
		foreach (lens[n]) begin
			mk_frame(lens[n]);
			u_mac.send(fr, n == 1);
			if (n != 1)
				expect_frame(1'b1);
		end
		drain(3000);
		wr(REG_CTRL, 32'h0);
		rd(REG_CTRL, 32'h0);
		whole_chk <= 1'b1;
		mk_frame(300);
		u_mac.send(fr, 1'b0);
		expect_frame(1'b0);
		drain(3000);
		whole_chk <= 1'b0;
		hold <= 1'b1;
		mk_frame(50);
		u_mac.send(fr, 1'b0);
		expect_frame(1'b0);
		repeat (300) @(posedge clk);
		`CHK(tx_q.size(), 50)
		hold <= 1'b0;
		slow <= 1'b1;
		drain(3000);
		// larger than storage: dropped, one pulse, then a good frame
		mk_frame(4100);
		u_mac.send(fr, 1'b0);
		mk_frame(64);
		u_mac.send(fr, 1'b0);
		expect_frame(1'b0);
		drain(9000);
		slow <= 1'b0;
		`CHK(rx_ovf_n, 1)
		// generator with checker, transmit echoed into receive
		strict <= 1'b0;
		loop <= 1'b1;
		wr(REG_CTRL, 32'h6);
		for (int l = 0; l < 3; l++)
			gen_expect(GEN_MIN_LEN + l[15:0]);
		drain(3000);
		repeat (400) @(posedge clk);
		`CHK(act_n > 2, 1'b1)
		rd(REG_STATUS, 32'h0, 32'h1);
		corrupt <= 1'b1;
		@(posedge clk);
		corrupt <= 1'b0;
		repeat (400) @(posedge clk);
		rd(REG_STATUS, 32'h1, 32'h1);
		repeat (200) @(posedge clk);
		rd(REG_STATUS, 32'h1, 32'h1);
		wr(REG_CLEAR, 32'h1);
		rd(REG_STATUS, 32'h0, 32'h1);
		@(posedge clk);
		`CHK(tx_ovf_n, 0)
		wrap_up();
	end
endmodule
`default_nettype wire
